// ---- logic/iesl_map.vh ----
// constants for the internal event standby logic
// How it works
// R1 - types 10, 11, 12 pick setpoint high, low, high/low limit
// R2 - types 13, 14, 15 pick controller output high, low, high/low
// R3 - types 16/18 burnout or overcurrent, 17/19 short, sensor one/two
// R4 - types 20, 21, 22 follow loop diagnosis one, two, three
// R5 - types 23..29 follow alarm, standby mode, manual, remote, tuning, ramp, direct
// R6 - type 31 follows estimated position control, 32 follows timer
// R7 - types 30 and 33 are accepted but always evaluate off
// R8 - type 33 is refused when firmware revision is below 2.04
// R9 - config digit one: 0 direct, 1 inverted output
// R10 - config digit two: 0 none, 1 standby, 2 standby plus setpoint change
// R11 - config digit three: 0 continue, 1 forced off in standby mode
// R12 - config digit four always zero; whole word resets to 0000
// R13 - with type 0 the config word reads zero and writes are refused
// R14 - standby holds the event off after power-up even if condition met
// R15 - standby looks at the condition before polarity
// R16 - standby ends on an off condition; a later on condition turns on
// R17 - mode 2 re-arms standby when the setpoint value changes
// R18 - an unchanged setpoint value never re-arms standby
// R19 - in standby mode event off if standby or forced; run entry re-arms
// R20 - eight channels with own type and config; inversion before output
`ifndef IESL_MAP_VH
`define IESL_MAP_VH
`define IESL_NCH 8
`define IESL_A_TYPE0 8'h00
`define IESL_A_EVENT 8'h10
`define IESL_A_STBY 8'h11
`define IESL_A_REJECT 8'h12
`define IESL_TYPE_RST 8'h00
`define IESL_CFG_RST 12'h000
`define IESL_T_NONE 8'd0
`define IESL_T_SP_HI 8'd10
`define IESL_T_SP_LO 8'd11
`define IESL_T_SP_HL 8'd12
`define IESL_T_OUT_HI 8'd13
`define IESL_T_OUT_LO 8'd14
`define IESL_T_OUT_HL 8'd15
`define IESL_T_CS1_BO 8'd16
`define IESL_T_CS1_SC 8'd17
`define IESL_T_CS2_BO 8'd18
`define IESL_T_CS2_SC 8'd19
`define IESL_T_DIAG1 8'd20
`define IESL_T_DIAG2 8'd21
`define IESL_T_DIAG3 8'd22
`define IESL_T_ALARM 8'd23
`define IESL_T_STBY 8'd24
`define IESL_T_MANUAL 8'd25
`define IESL_T_REMOTE 8'd26
`define IESL_T_TUNING 8'd27
`define IESL_T_RAMP 8'd28
`define IESL_T_DIRECT 8'd29
`define IESL_T_SELFTUNE 8'd30
`define IESL_T_ESTPOS 8'd31
`define IESL_T_TIMER 8'd32
`define IESL_T_FBPOS 8'd33
`define IESL_FW_MIN 16'h0204
`define IESL_POL_LSB 0
`define IESL_SB_LSB 4
`define IESL_RDY_LSB 8
`define IESL_SB_NONE 4'h0
`define IESL_SB_ON 4'h1
`define IESL_SB_SPCHG 4'h2
`endif

// ---- logic/iesl_events.v ----
// eight internal event channels with polarity, standby and ready handling
`timescale 1ns/1ps
`default_nettype none
`include "iesl_map.vh"

module iesl_events (
  input wire clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire [15:0] fw_revision,
  input wire [7:0] setpoint_hi,
  input wire [7:0] setpoint_lo,
  input wire [7:0] controller_output_hi,
  input wire [7:0] controller_output_lo,
  input wire current_sensor_one_burnout,
  input wire current_sensor_one_short,
  input wire current_sensor_two_burnout,
  input wire current_sensor_two_short,
  input wire [2:0] loop_diag,
  input wire alarm_any,
  input wire standby_mode,
  input wire manual_mode,
  input wire remote_setpoint,
  input wire autotuning,
  input wire setpoint_ramp,
  input wire direct_action,
  input wire est_position,
  input wire timer_status,
  input wire [15:0] setpoint_value,
  output reg [7:0] event_out,
  output reg reject_out
);

  localparam NCH = `IESL_NCH;

  wire [8*NCH-1:0] type_all;
  wire [12*NCH-1:0] cfg_all;
  wire [NCH-1:0] ev_d;
  wire [NCH-1:0] sb_all;

  reg ready_q;
  reg [15:0] sp_prev_q;
  reg sp_valid_q;
  reg reject_q;

  // run entry and setpoint change are single-cycle arming events
  wire run_entry = ready_q & ~standby_mode; // R19
  // compare against the last sampled value so equal rewrites are silent
  wire sp_change = sp_valid_q & (setpoint_value != sp_prev_q); // R17 R18

  wire chan_sel = (addr[7:4] == 4'h0);
  wire [2:0] ch_idx = addr[3:1];
  wire is_cfg = addr[0];

  reg [7:0] sel_type;
  reg [11:0] sel_cfg;
  always @* begin
    sel_type = type_all[8*ch_idx +: 8];
    sel_cfg = cfg_all[12*ch_idx +: 12];
  end

  // type write legality
  wire type_bad = (wdata[15:8] != 8'h00) || (wdata[7:0] > `IESL_T_FBPOS) ||
    ((wdata[7:0] == `IESL_T_FBPOS) && (fw_revision < `IESL_FW_MIN)); // R8

  // config write legality, digit four is simply forced to zero
  wire cfg_bad = (wdata[3:0] > 4'h1) || (wdata[7:4] > `IESL_SB_SPCHG) ||
    (wdata[11:8] > 4'h1) || (sel_type == `IESL_T_NONE); // R13

  wire wr_chan = wr & chan_sel;
  wire wr_ok = wr_chan & (is_cfg ? ~cfg_bad : ~type_bad);
  wire wr_bad = wr_chan & ~wr_ok;
  wire clr_reject = wr & (addr == `IESL_A_REJECT);

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg [7:0] type_q;
      reg [11:0] cfg_q;
      reg sb_q;
      reg cond;
      wire hit = wr_ok & (ch_idx == g);
      wire [3:0] pol = cfg_q[`IESL_POL_LSB +: 4];
      wire [3:0] sbm = cfg_q[`IESL_SB_LSB +: 4];
      wire [3:0] rdy = cfg_q[`IESL_RDY_LSB +: 4];
      wire sb_en = (sbm != `IESL_SB_NONE);
      wire arm = (run_entry & sb_en) | (sp_change & (sbm == `IESL_SB_SPCHG)); // R17 R19
      wire raw;
      wire inv;

      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          type_q <= `IESL_TYPE_RST;
          cfg_q <= `IESL_CFG_RST; // R12
        end else if (hit) begin
          if (is_cfg) begin
            cfg_q <= wdata[11:0]; // R9 R10 R11 R12
          end else begin
            type_q <= wdata[7:0]; // R20
          end
        end
      end

      always @* begin
        cond = 1'b0;
        case (type_q)
          `IESL_T_SP_HI: cond = setpoint_hi[g]; // R1
          `IESL_T_SP_LO: cond = setpoint_lo[g]; // R1
          `IESL_T_SP_HL: cond = setpoint_hi[g] | setpoint_lo[g]; // R1
          `IESL_T_OUT_HI: cond = controller_output_hi[g]; // R2
          `IESL_T_OUT_LO: cond = controller_output_lo[g]; // R2
          `IESL_T_OUT_HL: cond = controller_output_hi[g] | controller_output_lo[g]; // R2
          `IESL_T_CS1_BO: cond = current_sensor_one_burnout; // R3
          `IESL_T_CS1_SC: cond = current_sensor_one_short; // R3
          `IESL_T_CS2_BO: cond = current_sensor_two_burnout; // R3
          `IESL_T_CS2_SC: cond = current_sensor_two_short; // R3
          `IESL_T_DIAG1: cond = loop_diag[0]; // R4
          `IESL_T_DIAG2: cond = loop_diag[1]; // R4
          `IESL_T_DIAG3: cond = loop_diag[2]; // R4
          `IESL_T_ALARM: cond = alarm_any; // R5
          `IESL_T_STBY: cond = standby_mode; // R5
          `IESL_T_MANUAL: cond = manual_mode; // R5
          `IESL_T_REMOTE: cond = remote_setpoint; // R5
          `IESL_T_TUNING: cond = autotuning; // R5
          `IESL_T_RAMP: cond = setpoint_ramp; // R5
          `IESL_T_DIRECT: cond = direct_action; // R5
          `IESL_T_ESTPOS: cond = est_position; // R6
          `IESL_T_TIMER: cond = timer_status; // R6
          `IESL_T_SELFTUNE: cond = 1'b0; // R7
          `IESL_T_FBPOS: cond = 1'b0; // R7
          default: cond = 1'b0;
        endcase
      end

      // standby flag: set from reset, cleared by an off condition
      // only an enabled channel may clear it, so setup after reset keeps it armed
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sb_q <= 1'b1; // R14
        end else if (arm) begin
          sb_q <= 1'b1; // R17 R19
        end else if (sb_en && !cond) begin
          sb_q <= 1'b0; // R15 R16
        end
      end

      assign raw = cond & ~(sb_en & sb_q); // R14 R15 R16
      assign inv = (pol == 4'h1);
      // inversion applies only once standby has let the channel through
      assign ev_d[g] = (type_q == `IESL_T_NONE) ? 1'b0 :
        (standby_mode & (sb_en | (rdy == 4'h1))) ? 1'b0 : // R11 R19
        (sb_en & sb_q) ? 1'b0 :
        (raw ^ inv); // R9 R20
      assign sb_all[g] = sb_en & sb_q;
      assign type_all[8*g +: 8] = type_q;
      assign cfg_all[12*g +: 12] = cfg_q;
    end
  endgenerate

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ready_q <= 1'b0;
      sp_prev_q <= 16'h0000;
      sp_valid_q <= 1'b0;
    end else begin
      ready_q <= standby_mode;
      sp_prev_q <= setpoint_value;
      sp_valid_q <= 1'b1;
    end
  end

  // set wins over the software clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reject_q <= 1'b0;
    end else if (wr_bad) begin
      reject_q <= 1'b1; // R8 R13
    end else if (clr_reject) begin
      reject_q <= 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_out <= 8'h00;
      reject_out <= 1'b0;
    end else begin
      event_out <= ev_d; // R20
      reject_out <= reject_q;
    end
  end

  // read data stand for exactly one cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (chan_sel && is_cfg) begin
        rdata <= (sel_type == `IESL_T_NONE) ? 16'h0000 : {4'h0, sel_cfg}; // R12 R13
      end else if (chan_sel) begin
        rdata <= {8'h00, sel_type};
      end else if (addr == `IESL_A_EVENT) begin
        rdata <= {8'h00, event_out};
      end else if (addr == `IESL_A_STBY) begin
        rdata <= {8'h00, sb_all};
      end else if (addr == `IESL_A_REJECT) begin
        rdata <= {15'h0000, reject_q};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // iesl_events
`default_nettype wire

// ---- verif/iesl_events_properties.sv ----
// port-level checks for the internal event logic
`timescale 1ns/1ps
`default_nettype none
module iesl_events_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [15:0] fw_revision,
  input wire logic [7:0] event_out,
  input wire logic reject_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire tw = wr && addr < 8'h10 && !addr[0];
  wire cw = wr && addr < 8'h10 && addr[0];
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata idle");
  a_event_read: assert property (rd && addr == 8'h10 |=> rdata == {8'h00, $past(event_out)})
    else $error("event read");
  a_unmapped_zero: assert property (rd && addr > 8'h12 |=> rdata == 16'h0000) else $error("unmapped");
  a_old_fw: assert property (tw && wdata == 16'h0021 && fw_revision < 16'h0204 |-> ##[1:2] reject_out)
    else $error("old fw");
  a_type_range: assert property (tw && wdata > 16'h0021 |-> ##[1:2] reject_out) else $error("type");
  a_pol_digit: assert property (cw && wdata[3:0] > 4'h1 |-> ##[1:2] reject_out) else $error("pol");
  a_sb_digit: assert property (cw && wdata[7:4] > 4'h2 |-> ##[1:2] reject_out) else $error("sb");
  a_rdy_digit: assert property (cw && wdata[11:8] > 4'h1 |-> ##[1:2] reject_out) else $error("rdy");
  a_reject_clear: assert property (wr && addr == 8'h12 |-> ##2 !reject_out) else $error("clear");
  c_fw: cover property (tw && wdata == 16'h0021);
  c_read: cover property (rd && addr == 8'h10);
  c_rej: cover property ($rose(reject_out));
endmodule // iesl_events_chk
bind iesl_events iesl_events_chk u_chk (.*);
`default_nettype wire

// ---- verif/tb_iesl_events.sv ----
// self-checking bench for the internal event logic
`timescale 1ns/1ps
`default_nettype none
module tb_iesl_events;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, src = 1'b0, alarm = 1'b0, rdy = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, fw = 16'h0204, spv = 16'h0000;
  logic [15:0] rdata;
  logic [7:0] event_out;
  logic reject_out;
  int failures = 0, total_checks = 0;
  always #10 clk = ~clk;
  // one source level fans into every condition input except alarm_any and standby_mode, which have their own levels
  iesl_events DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fw_revision(fw), .setpoint_hi({8{src}}), .setpoint_lo({8{src}}),
    .controller_output_hi({8{src}}), .controller_output_lo({8{src}}),
    .current_sensor_one_burnout(src), .current_sensor_one_short(src),
    .current_sensor_two_burnout(src), .current_sensor_two_short(src), .loop_diag({3{src}}),
    .alarm_any(alarm), .standby_mode(rdy), .manual_mode(src), .remote_setpoint(src),
    .autotuning(src), .setpoint_ramp(src), .direct_action(src), .est_position(src),
    .timer_status(src), .setpoint_value(spv), .event_out(event_out), .reject_out(reject_out));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic ev(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, event_out[0]}, {15'h0000, e});
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_codes;
    rreg(8'h00, 16'h0000);
    rreg(8'h01, 16'h0000);
    rreg(8'h13, 16'h0000);
    @(posedge clk) src <= 1'b1;
    alarm <= 1'b1;
    rdy <= 1'b1;
    // reserved types stay off with every source active
    for (int t = 10; t <= 33; t++) begin
      wreg(8'h00, 16'(t));
      ev(t != 30 && t != 33);
    end
    @(posedge clk) src <= 1'b0;
    rdy <= 1'b0;
    wreg(8'h00, 16'h000a);
    ev(1'b0);
  endtask
  task automatic t_pol;
    wreg(8'h00, 16'h0017);
    wreg(8'h01, 16'h0001);
    @(posedge clk) alarm <= 1'b0;
    ev(1'b1);
    @(posedge clk) alarm <= 1'b1;
    ev(1'b0);
    rreg(8'h10, 16'h0000);
  endtask
  task automatic t_stby;
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wreg(8'h00, 16'h0017);
    wreg(8'h01, 16'h0010);
    ev(1'b0);
    @(posedge clk) alarm <= 1'b0;
    ev(1'b0);
    @(posedge clk) alarm <= 1'b1;
    ev(1'b1);
    wreg(8'h01, 16'h0020);
    @(posedge clk) spv <= 16'h0000;
    ev(1'b1);
    @(posedge clk) spv <= 16'h0123;
    ev(1'b0);
    @(posedge clk) alarm <= 1'b0;
    ev(1'b0);
    @(posedge clk) alarm <= 1'b1;
    ev(1'b1);
  endtask
  task automatic t_ready;
    wreg(8'h01, 16'h0100);
    @(posedge clk) rdy <= 1'b1;
    ev(1'b0);
    wreg(8'h01, 16'h0000);
    ev(1'b1);
    wreg(8'h01, 16'h0010);
    ev(1'b0);
    @(posedge clk) rdy <= 1'b0;
    ev(1'b0);
  endtask
  task automatic t_refuse;
    @(posedge clk) fw <= 16'h0203;
    wreg(8'h02, 16'h0021);
    rreg(8'h02, 16'h0000);
    rreg(8'h12, 16'h0001);
    chk({15'h0000, reject_out}, 16'h0001);
    @(posedge clk) fw <= 16'h0204;
    wreg(8'h12, 16'h0000);
    wreg(8'h02, 16'h0021);
    rreg(8'h02, 16'h0021);
    rreg(8'h12, 16'h0000);
    wreg(8'h03, 16'hf001);
    rreg(8'h03, 16'h0001);
    wreg(8'h01, 16'h0232);
    wreg(8'h02, 16'h0028);
    rreg(8'h01, 16'h0010);
    wreg(8'h01, 16'h0030);
    wreg(8'h01, 16'h0200);
    rreg(8'h01, 16'h0010);
    wreg(8'h02, 16'h0000);
    rreg(8'h03, 16'h0000);
    wreg(8'h12, 16'h0000);
    wreg(8'h03, 16'h0001);
    rreg(8'h12, 16'h0001);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_codes;
    t_pol;
    t_stby;
    t_ready;
    t_refuse;
    finish_test;
  end
  initial begin
    #1000000;
    failures++;
    finish_test;
  end
endmodule // tb_iesl_events
`default_nettype wire
